// File: timer0_defs.vh
// Function
// - Counter is readable and writable by software through counter_value.
// - A counter_value write blocks compare matches on the next timer tick.
// - compare_a_value is compared with the counter; a match raises flag A and drives wave_out_a.
// - compare_b_value is compared with the counter; a match raises flag B and drives wave_out_b.
// - compare_a_flag sits at bit 1 and sets on a compare A match.
// - compare_b_flag sits at bit 2 and sets on a compare B match.
// - overflow_flag sits at bit 0 and sets on counter overflow.
// - The overflow point depends on the waveform_select mode.
// - Each flag clears when the CPU executes its interrupt vector.
// - Writing one to a flag bit clears it; writing zero leaves it.
// - Compare B request needs global enable, compare B enable and compare B flag.
// - Compare A request needs global enable, compare A enable and compare A flag.
// - Overflow request needs global enable, overflow enable and overflow flag.
// - Registers decode at data offsets, or offset minus 0x20 under I/O access.
// - counter_value sits at 0x46, alias 0x26, and resets to 0x00.
// - Flag register sits at 0x35, alias 0x15, and all flags reset to zero.
// - Each interrupt source is enabled only once software sets its enable bit.
`ifndef TIMER0_DEFS_VH
`define TIMER0_DEFS_VH

`define IO_BASE            8'h20
`define IO_LIMIT           8'h3f
`define OFF_FLAGS          8'h35
`define OFF_COUNT          8'h46
`define OFF_CMP_A          8'h47
`define OFF_CMP_B          8'h48

`define RST_FLAGS          3'h0
`define RST_COUNT          8'h00
`define RST_CMP            8'h00

`define BIT_OVF            0
`define BIT_CMP_A          1
`define BIT_CMP_B          2

`define CNT_BOTTOM         8'h00
`define CNT_MAX            8'hff

`define WGM_NORMAL         3'h0
`define WGM_PC_FF          3'h1
`define WGM_CTC            3'h2
`define WGM_FAST_FF        3'h3
`define WGM_PC_OCRA        3'h5
`define WGM_FAST_OCRA      3'h7

`define CS_STOP            3'h0
`define CS_DIV1            3'h1
`define CS_DIV8            3'h2
`define CS_DIV64           3'h3
`define CS_DIV256          3'h4
`define CS_DIV1024         3'h5
`define CS_EXT_FALL        3'h6
`define CS_EXT_RISE        3'h7

`define COM_OFF            2'h0
`define COM_TOGGLE         2'h1
`define COM_CLEAR          2'h2
`define COM_SET            2'h3

`endif

// File: tick_select.v
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defs.vh"

module tick_select #(
    parameter PRE_W = 10
) (
    // Clock and reset.
    input  wire       clk,
    input  wire       rst_n,
    // Source selection and external pin.
    input  wire [2:0] clock_select,
    input  wire       ext_clk_pin,
    // Timer tick.
    output reg        tick_q
);
    reg [PRE_W-1:0] pre_q;
    reg             pin_q;
    reg             tick_d;

    always @* begin
        case (clock_select)
            `CS_STOP:     tick_d = 1'b0;
            `CS_DIV1:     tick_d = 1'b1;
            `CS_DIV8:     tick_d = &pre_q[2:0];
            `CS_DIV64:    tick_d = &pre_q[5:0];
            `CS_DIV256:   tick_d = &pre_q[7:0];
            `CS_DIV1024:  tick_d = &pre_q[9:0];
            `CS_EXT_FALL: tick_d = pin_q & ~ext_clk_pin;
            `CS_EXT_RISE: tick_d = ~pin_q & ext_clk_pin;
            default:      tick_d = 1'b0;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q  <= {PRE_W{1'b0}};
            pin_q  <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
            pin_q  <= ext_clk_pin;
            tick_q <= tick_d;
        end
    end
endmodule
`default_nettype wire

// File: compare_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defs.vh"

module compare_unit #(
    parameter W = 8
) (
    // Clock and reset.
    input  wire         clk,
    input  wire         rst_n,
    // Counter state.
    input  wire [W-1:0] count,
    input  wire         tick,
    input  wire         block,
    input  wire         counting_up,
    input  wire         at_bottom,
    // Mode and compare value.
    input  wire [W-1:0] cmp_value,
    input  wire [1:0]   out_mode,
    input  wire         pwm_fast,
    input  wire         pwm_phase,
    input  wire         force_match,
    // Results.
    output wire         match,
    output reg          wave_q
);
    reg wave_d;

    assign match = tick & ~block & (count == cmp_value);

    always @* begin
        wave_d = wave_q;
        if (pwm_fast) begin
            if (out_mode[1] && match)
                wave_d = out_mode[0];
            else if (out_mode[1] && tick && at_bottom)
                wave_d = ~out_mode[0];
        end else if (pwm_phase) begin
            if (out_mode[1] && match)
                wave_d = out_mode[0] ^ ~counting_up;
        end else if (match || force_match) begin
            case (out_mode)
                `COM_TOGGLE: wave_d = ~wave_q;
                `COM_CLEAR:  wave_d = 1'b0;
                `COM_SET:    wave_d = 1'b1;
                default:     wave_d = wave_q;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            wave_q <= 1'b0;
        else
            wave_q <= wave_d;
    end
endmodule
`default_nettype wire

// File: timer0_core.v
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defs.vh"

module timer0_core #(
    parameter CNT_W = 8
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             rst_n,
    // CPU register port.
    input  wire [7:0]       addr,
    input  wire             io_space,
    input  wire             wr_en,
    input  wire             rd_en,
    input  wire [7:0]       wdata,
    output reg  [7:0]       rdata_q,
    // Timer configuration from the rest of the timer.
    input  wire [2:0]       waveform_select,
    input  wire [2:0]       clock_select,
    input  wire [1:0]       out_mode_a,
    input  wire [1:0]       out_mode_b,
    input  wire             force_a,
    input  wire             force_b,
    input  wire             ext_clk_pin,
    // Interrupt enables and vector acknowledges.
    input  wire             global_irq_enable,
    input  wire             compare_a_irq_enable,
    input  wire             compare_b_irq_enable,
    input  wire             overflow_irq_enable,
    input  wire             vector_ack_a,
    input  wire             vector_ack_b,
    input  wire             vector_ack_ovf,
    // Interrupt requests and waveform pins.
    output reg              irq_compare_a_q,
    output reg              irq_compare_b_q,
    output reg              irq_overflow_q,
    output wire             wave_out_a,
    output wire             wave_out_b
);
    // Maps a CPU access to its data-space offset and tests it against one register.
    function reg_hit;
        input [7:0] a;
        input       io;
        input [7:0] off;
        begin
            if (io)
                reg_hit = (a <= `IO_LIMIT) && ((a + `IO_BASE) == off);
            else
                reg_hit = (a == off);
        end
    endfunction

    reg  [CNT_W-1:0] counter_value_q;
    reg  [CNT_W-1:0] counter_value_d;
    reg  [CNT_W-1:0] compare_a_value_q;
    reg  [CNT_W-1:0] compare_b_value_q;
    reg  [CNT_W-1:0] cmp_a_act_q;
    reg  [CNT_W-1:0] cmp_b_act_q;
    reg  [2:0]       flags_q;
    reg  [2:0]       flags_d;
    reg              up_q;
    reg              up_d;
    reg              block_q;
    reg              overflow_evt;
    reg  [CNT_W-1:0] top;
    reg  [7:0]       rdata_d;
    wire             tick;
    wire             match_a;
    wire             match_b;

    wire sel_flags = reg_hit(addr, io_space, `OFF_FLAGS);
    wire sel_count = reg_hit(addr, io_space, `OFF_COUNT);
    wire sel_cmp_a = reg_hit(addr, io_space, `OFF_CMP_A);
    wire sel_cmp_b = reg_hit(addr, io_space, `OFF_CMP_B);

    wire wr_count  = wr_en & sel_count;

    // Mode decode.
    wire mode_fast  = (waveform_select == `WGM_FAST_FF) || (waveform_select == `WGM_FAST_OCRA);
    wire mode_phase = (waveform_select == `WGM_PC_FF) || (waveform_select == `WGM_PC_OCRA);
    wire mode_ctc   = (waveform_select == `WGM_CTC);
    wire top_is_a   = mode_ctc || (waveform_select == `WGM_PC_OCRA) ||
                      (waveform_select == `WGM_FAST_OCRA);
    wire at_top     = (counter_value_q == top);
    wire at_bottom  = (counter_value_q == `CNT_BOTTOM);

    // Forcing is only honoured outside PWM modes.
    wire force_a_ok = force_a & ~mode_fast & ~mode_phase;
    wire force_b_ok = force_b & ~mode_fast & ~mode_phase;

    tick_select #(
        .PRE_W(10)
    ) u_tick (
        .clk          (clk),
        .rst_n        (rst_n),
        .clock_select (clock_select),
        .ext_clk_pin  (ext_clk_pin),
        .tick_q       (tick)
    );

    compare_unit #(
        .W(CNT_W)
    ) u_cmp_a (
        .clk         (clk),
        .rst_n       (rst_n),
        .count       (counter_value_q),
        .tick        (tick),
        .block       (block_q),
        .counting_up (up_q),
        .at_bottom   (at_top),
        .cmp_value   (cmp_a_act_q),
        .out_mode    (out_mode_a),
        .pwm_fast    (mode_fast),
        .pwm_phase   (mode_phase),
        .force_match (force_a_ok),
        .match       (match_a),
        .wave_q      (wave_out_a)
    );

    compare_unit #(
        .W(CNT_W)
    ) u_cmp_b (
        .clk         (clk),
        .rst_n       (rst_n),
        .count       (counter_value_q),
        .tick        (tick),
        .block       (block_q),
        .counting_up (up_q),
        .at_bottom   (at_top),
        .cmp_value   (cmp_b_act_q),
        .out_mode    (out_mode_b),
        .pwm_fast    (mode_fast),
        .pwm_phase   (mode_phase),
        .force_match (force_b_ok),
        .match       (match_b),
        .wave_q      (wave_out_b)
    );

    // Counter sequencing per waveform mode.
    always @* begin
        top             = top_is_a ? cmp_a_act_q : `CNT_MAX;
        counter_value_d = counter_value_q;
        up_d            = up_q;
        overflow_evt    = 1'b0;
        if (wr_count) begin
            counter_value_d = wdata[CNT_W-1:0];
        end else if (tick) begin
            if (mode_phase) begin
                if (up_q) begin
                    if (at_top) begin
                        up_d            = 1'b0;
                        counter_value_d = counter_value_q - {{(CNT_W-1){1'b0}}, 1'b1};
                    end else begin
                        counter_value_d = counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end else begin
                    if (at_bottom) begin
                        up_d            = 1'b1;
                        overflow_evt    = 1'b1;
                        counter_value_d = counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
                    end else begin
                        counter_value_d = counter_value_q - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end else if (mode_ctc) begin
                up_d = 1'b1;
                if (at_top)
                    counter_value_d = `CNT_BOTTOM;
                else
                    counter_value_d = counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
                overflow_evt = (counter_value_q == `CNT_MAX);
            end else begin
                up_d = 1'b1;
                if (at_top) begin
                    counter_value_d = `CNT_BOTTOM;
                    overflow_evt    = 1'b1;
                end else begin
                    counter_value_d = counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Flag next state: hardware set wins over either kind of clear.
    always @* begin
        flags_d = flags_q;
        if (wr_en && sel_flags) begin
            if (wdata[`BIT_OVF])
                flags_d[`BIT_OVF] = 1'b0;
            if (wdata[`BIT_CMP_A])
                flags_d[`BIT_CMP_A] = 1'b0;
            if (wdata[`BIT_CMP_B])
                flags_d[`BIT_CMP_B] = 1'b0;
        end
        if (vector_ack_ovf)
            flags_d[`BIT_OVF] = 1'b0;
        if (vector_ack_a)
            flags_d[`BIT_CMP_A] = 1'b0;
        if (vector_ack_b)
            flags_d[`BIT_CMP_B] = 1'b0;
        if (overflow_evt)
            flags_d[`BIT_OVF] = 1'b1;
        if (match_a)
            flags_d[`BIT_CMP_A] = 1'b1;
        if (match_b)
            flags_d[`BIT_CMP_B] = 1'b1;
    end

    // Read mux; unmapped offsets read as zero.
    always @* begin
        rdata_d = 8'h00;
        if (sel_flags)
            rdata_d = {5'h00, flags_q};
        else if (sel_count)
            rdata_d = counter_value_q;
        else if (sel_cmp_a)
            rdata_d = compare_a_value_q;
        else if (sel_cmp_b)
            rdata_d = compare_b_value_q;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_q   <= `RST_COUNT;
            compare_a_value_q <= `RST_CMP;
            compare_b_value_q <= `RST_CMP;
            cmp_a_act_q       <= `RST_CMP;
            cmp_b_act_q       <= `RST_CMP;
            flags_q           <= `RST_FLAGS;
            up_q              <= 1'b1;
            block_q           <= 1'b0;
            rdata_q           <= 8'h00;
            irq_compare_a_q   <= 1'b0;
            irq_compare_b_q   <= 1'b0;
            irq_overflow_q    <= 1'b0;
        end else begin
            counter_value_q <= counter_value_d;
            up_q            <= up_d;
            flags_q         <= flags_d;
            // A counter write masks the match on the following tick only.
            if (wr_count)
                block_q <= 1'b1;
            else if (tick)
                block_q <= 1'b0;
            if (wr_en && sel_cmp_a)
                compare_a_value_q <= wdata[CNT_W-1:0];
            if (wr_en && sel_cmp_b)
                compare_b_value_q <= wdata[CNT_W-1:0];
            // PWM modes take new compare values at TOP only.
            if (!(mode_fast || mode_phase) ||
                (tick && mode_fast && at_top) ||
                (tick && mode_phase && up_q && at_top)) begin
                cmp_a_act_q <= compare_a_value_q;
                cmp_b_act_q <= compare_b_value_q;
            end
            if (rd_en)
                rdata_q <= rdata_d;
            else
                rdata_q <= 8'h00;
            irq_compare_a_q <= global_irq_enable & compare_a_irq_enable & flags_d[`BIT_CMP_A];
            irq_compare_b_q <= global_irq_enable & compare_b_irq_enable & flags_d[`BIT_CMP_B];
            irq_overflow_q  <= global_irq_enable & overflow_irq_enable & flags_d[`BIT_OVF];
        end
    end
endmodule
`default_nettype wire

// File: cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
    // Clock.
    input  wire        clk,
    // Register port toward the timer.
    output logic [7:0] addr,
    output logic       io_space,
    output logic       wr_en,
    output logic       rd_en,
    output logic [7:0] wdata,
    input  wire  [7:0] rdata_q
);
    initial begin
        addr     = 8'h00;
        io_space = 1'b0;
        wr_en    = 1'b0;
        rd_en    = 1'b0;
        wdata    = 8'h00;
    end

    // Released address and data lines carry the inverse of the last value so that a stale value can never pass.
    task write_reg(input logic io, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io_space <= io;
        addr     <= a;
        wdata    <= d;
        wr_en    <= 1'b1;
        @(posedge clk);
        wr_en    <= 1'b0;
        addr     <= ~a;
        wdata    <= ~d;
    endtask

    task read_reg(input logic io, input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        io_space <= io;
        addr     <= a;
        rd_en    <= 1'b1;
        @(posedge clk);
        rd_en    <= 1'b0;
        addr     <= ~a;
        #1;
        d = rdata_q;
    endtask
endmodule

`default_nettype wire

// File: timer0_core_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defs.vh"

module timer0_core_props #(
    parameter CNT_W = 8
) (
    // Clock and reset.
    input wire       clk,
    input wire       rst_n,
    // Register port.
    input wire [7:0] addr,
    input wire       io_space,
    input wire       rd_en,
    input wire [7:0] rdata_q,
    // Timer controls.
    input wire [2:0] clock_select,
    input wire       global_irq_enable,
    input wire       compare_a_irq_enable,
    input wire       compare_b_irq_enable,
    input wire       overflow_irq_enable,
    input wire       vector_ack_a,
    input wire       vector_ack_b,
    input wire       vector_ack_ovf,
    // Requests.
    input wire       irq_compare_a_q,
    input wire       irq_compare_b_q,
    input wire       irq_overflow_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire [7:0] off = io_space ? addr + `IO_BASE : addr;
    wire       hit = (!io_space || addr <= `IO_LIMIT) &&
                     (off == `OFF_FLAGS || off == `OFF_COUNT || off == `OFF_CMP_A || off == `OFF_CMP_B);

    // No timer tick can land while the clock source has been stopped for two cycles.
    sequence s_stop_ack_a;
        clock_select == `CS_STOP ##1 clock_select == `CS_STOP && vector_ack_a;
    endsequence
    sequence s_stop_ack_b;
        clock_select == `CS_STOP ##1 clock_select == `CS_STOP && vector_ack_b;
    endsequence
    sequence s_stop_ack_ovf;
        clock_select == `CS_STOP ##1 clock_select == `CS_STOP && vector_ack_ovf;
    endsequence

    a_irq_a_gate: assert property (irq_compare_a_q |-> $past(global_irq_enable && compare_a_irq_enable))
        else $error("compare A request without its enables");
    a_irq_b_gate: assert property (irq_compare_b_q |-> $past(global_irq_enable && compare_b_irq_enable))
        else $error("compare B request without its enables");
    a_irq_ovf_gate: assert property (irq_overflow_q |-> $past(global_irq_enable && overflow_irq_enable))
        else $error("overflow request without its enables");
    a_read_idle_zero: assert property (!$past(rd_en) |-> rdata_q == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property ($past(rd_en && !hit) |-> rdata_q == 8'h00)
        else $error("unmapped read returned data");
    a_flags_upper_zero: assert property ($past(rd_en && hit && off == `OFF_FLAGS) |-> rdata_q[7:3] == 5'h00)
        else $error("flag register upper bits not zero");
    a_ack_a_clears: assert property (s_stop_ack_a |=> !irq_compare_a_q)
        else $error("compare A vector did not clear the request");
    a_ack_ovf_clears: assert property (s_stop_ack_ovf |=> !irq_overflow_q)
        else $error("overflow vector did not clear the request");
    a_ack_b_clears: assert property (s_stop_ack_b |=> !irq_compare_b_q)
        else $error("compare B vector did not clear the request");
endmodule

bind timer0_core timer0_core_props #(.CNT_W(CNT_W)) u_timer0_core_props (
    .clk, .rst_n, .addr, .io_space, .rd_en, .rdata_q, .clock_select, .global_irq_enable,
    .compare_a_irq_enable, .compare_b_irq_enable, .overflow_irq_enable, .vector_ack_a, .vector_ack_b,
    .vector_ack_ovf, .irq_compare_a_q, .irq_compare_b_q, .irq_overflow_q
);

`default_nettype wire

// File: timer0_compare_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defs.vh"

module timer0_compare_flags_bench;
    reg        clk, rst_n, force_a, force_b, ext_clk_pin;
    reg  [2:0] waveform_select, clock_select;
    reg  [1:0] out_mode_a, out_mode_b;
    reg        global_irq_enable, compare_a_irq_enable, compare_b_irq_enable, overflow_irq_enable;
    reg        vector_ack_a, vector_ack_b, vector_ack_ovf;
    wire [7:0] addr, wdata, rdata_q;
    wire       io_space, wr_en, rd_en, irq_compare_a_q, irq_compare_b_q, irq_overflow_q, wave_out_a, wave_out_b;
    integer    error_cnt, compares, i;
    reg  [7:0] rd;
    reg  [7:0] offs [0:2];

    cpu_bus_model u_cpu_bus_model (.clk(clk), .addr(addr), .io_space(io_space), .wr_en(wr_en), .rd_en(rd_en),
        .wdata(wdata), .rdata_q(rdata_q));
    timer0_core #(.CNT_W(8)) u_timer0_core (.clk(clk), .rst_n(rst_n), .addr(addr), .io_space(io_space),
        .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata_q(rdata_q), .waveform_select(waveform_select),
        .clock_select(clock_select), .out_mode_a(out_mode_a), .out_mode_b(out_mode_b), .force_a(force_a),
        .force_b(force_b), .ext_clk_pin(ext_clk_pin), .global_irq_enable(global_irq_enable),
        .compare_a_irq_enable(compare_a_irq_enable), .compare_b_irq_enable(compare_b_irq_enable),
        .overflow_irq_enable(overflow_irq_enable), .vector_ack_a(vector_ack_a), .vector_ack_b(vector_ack_b),
        .vector_ack_ovf(vector_ack_ovf), .irq_compare_a_q(irq_compare_a_q), .irq_compare_b_q(irq_compare_b_q),
        .irq_overflow_q(irq_overflow_q), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task check(input [7:0] seen, input [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task rd_check(input io, input [7:0] a, input [7:0] exp);
        u_cpu_bus_model.read_reg(io, a, rd);
        check(rd, exp);
    endtask

    task wr(input io, input [7:0] a, input [7:0] d);
        u_cpu_bus_model.write_reg(io, a, d);
    endtask

    // Divide-by-one ticks land one cycle late, so n cycles of running give exactly n counts.
    task run(input integer n);
        @(posedge clk);
        clock_select <= `CS_DIV1;
        repeat (n) @(posedge clk);
        clock_select <= `CS_STOP;
        repeat (3) @(posedge clk);
    endtask

    task settle(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task test_done;
        $display("comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        test_done;
    end

    initial begin
        error_cnt = 0; compares = 0; rst_n = 1'b0; force_a = 1'b0; force_b = 1'b0; ext_clk_pin = 1'b0;
        waveform_select = `WGM_NORMAL; clock_select = `CS_STOP; out_mode_a = `COM_TOGGLE; out_mode_b = `COM_SET;
        global_irq_enable = 1'b0; compare_a_irq_enable = 1'b0; compare_b_irq_enable = 1'b0;
        overflow_irq_enable = 1'b0; vector_ack_a = 1'b0; vector_ack_b = 1'b0; vector_ack_ovf = 1'b0;
        offs[0] = `OFF_COUNT; offs[1] = `OFF_CMP_A; offs[2] = `OFF_CMP_B;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_check(1'b0, `OFF_COUNT, `RST_COUNT);
        rd_check(1'b0, `OFF_CMP_A, `RST_CMP);
        rd_check(1'b0, `OFF_CMP_B, `RST_CMP);
        rd_check(1'b1, `OFF_FLAGS - `IO_BASE, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            wr(1'b1, offs[i] - `IO_BASE, 8'h9a + i[7:0]);
            rd_check(1'b0, offs[i], 8'h9a + i[7:0]);
            wr(1'b0, offs[i], 8'hc5 + i[7:0]);
            rd_check(1'b1, offs[i] - `IO_BASE, 8'hc5 + i[7:0]);
        end
        wr(1'b0, 8'h49, 8'hff);
        rd_check(1'b0, 8'h49, 8'h00);
        rd_check(1'b1, `OFF_COUNT, 8'h00);
        wr(1'b0, `OFF_COUNT, 8'h10);
        settle(10);
        rd_check(1'b0, `OFF_COUNT, 8'h10);
        run(6);
        rd_check(1'b0, `OFF_COUNT, 8'h16);
        wr(1'b0, `OFF_CMP_A, 8'h20);
        wr(1'b0, `OFF_CMP_B, 8'h40);
        wr(1'b0, `OFF_FLAGS, 8'h07);
        rd_check(1'b0, `OFF_FLAGS, 8'h00);
        wr(1'b0, `OFF_COUNT, 8'h1e);
        run(8);
        rd_check(1'b0, `OFF_FLAGS, 8'h02);
        check({7'h00, wave_out_a}, 8'h01);
        check({7'h00, wave_out_b}, 8'h00);
        wr(1'b0, `OFF_FLAGS, 8'h05);
        rd_check(1'b0, `OFF_FLAGS, 8'h02);
        @(posedge clk) global_irq_enable <= 1'b1;
        settle(2);
        check({7'h00, irq_compare_a_q}, 8'h00);
        @(posedge clk) compare_a_irq_enable <= 1'b1;
        settle(2);
        check({7'h00, irq_compare_a_q}, 8'h01);
        @(posedge clk) global_irq_enable <= 1'b0;
        settle(2);
        check({7'h00, irq_compare_a_q}, 8'h00);
        @(posedge clk) global_irq_enable <= 1'b1;
        @(posedge clk) vector_ack_a <= 1'b1;
        @(posedge clk) vector_ack_a <= 1'b0;
        settle(1);
        check({7'h00, irq_compare_a_q}, 8'h00);
        rd_check(1'b0, `OFF_FLAGS, 8'h00);
        wr(1'b0, `OFF_COUNT, 8'h40);
        run(3);
        rd_check(1'b0, `OFF_FLAGS, 8'h00);
        wr(1'b0, `OFF_COUNT, 8'h3f);
        run(3);
        rd_check(1'b0, `OFF_FLAGS, 8'h04);
        check({7'h00, wave_out_b}, 8'h01);
        @(posedge clk) compare_b_irq_enable <= 1'b1;
        settle(2);
        check({7'h00, irq_compare_b_q}, 8'h01);
        wr(1'b0, `OFF_FLAGS, 8'h04);
        settle(1);
        check({7'h00, irq_compare_b_q}, 8'h00);
        wr(1'b0, `OFF_COUNT, 8'hfc);
        run(8);
        rd_check(1'b0, `OFF_FLAGS, 8'h01);
        @(posedge clk) overflow_irq_enable <= 1'b1;
        settle(2);
        check({7'h00, irq_overflow_q}, 8'h01);
        @(posedge clk) vector_ack_ovf <= 1'b1;
        @(posedge clk) vector_ack_ovf <= 1'b0;
        settle(1);
        check({7'h00, irq_overflow_q}, 8'h00);
        rd_check(1'b0, `OFF_FLAGS, 8'h00);
        wr(1'b0, `OFF_CMP_A, 8'h30);
        @(posedge clk) waveform_select <= `WGM_FAST_OCRA;
        wr(1'b0, `OFF_COUNT, 8'h28);
        run(12);
        u_cpu_bus_model.read_reg(1'b0, `OFF_FLAGS, rd);
        check(rd & 8'h01, 8'h01);
        wr(1'b0, `OFF_FLAGS, 8'h07);
        @(posedge clk) waveform_select <= `WGM_CTC;
        wr(1'b0, `OFF_COUNT, 8'h2e);
        run(4);
        rd_check(1'b0, `OFF_FLAGS, 8'h02);
        rd_check(1'b0, `OFF_COUNT, 8'h01);
        wr(1'b0, `OFF_COUNT, 8'hfe);
        run(3);
        rd_check(1'b0, `OFF_FLAGS, 8'h03);
        wr(1'b0, `OFF_FLAGS, 8'h07);
        wr(1'b0, `OFF_COUNT, 8'h3f);
        run(3);
        rd_check(1'b0, `OFF_FLAGS, 8'h04);
        check({7'h00, irq_compare_b_q}, 8'h01);
        @(posedge clk) vector_ack_b <= 1'b1;
        @(posedge clk) vector_ack_b <= 1'b0;
        settle(1);
        check({7'h00, irq_compare_b_q}, 8'h00);
        rd_check(1'b0, `OFF_FLAGS, 8'h00);
        @(posedge clk) begin
            out_mode_a <= `COM_SET;
            force_a    <= 1'b1;
        end
        @(posedge clk) force_a <= 1'b0;
        settle(1);
        check({7'h00, wave_out_a}, 8'h01);
        rd_check(1'b0, `OFF_FLAGS, 8'h00);
        wr(1'b0, `OFF_COUNT, 8'h00);
        @(posedge clk) clock_select <= `CS_DIV8;
        repeat (16) @(posedge clk);
        clock_select <= `CS_EXT_RISE;
        repeat (3) begin
            @(posedge clk) ext_clk_pin <= 1'b1;
            @(posedge clk) ext_clk_pin <= 1'b0;
        end
        @(posedge clk) clock_select <= `CS_STOP;
        settle(2);
        rd_check(1'b0, `OFF_COUNT, 8'h05);
        test_done;
    end
endmodule

`default_nettype wire
